//--- include/dtg_pkg.sv
/*
 holds the timing constants and command codes shared by the
 controller end and the memory end of the command timing guard.
 assumes one 125 MHz clock (8 ns) for both ends.
*/
`default_nettype none
package dtg_pkg;
   localparam int CLK_PS = 8000;
   // limits as printed, in picoseconds so fractions stay exact, bar the refresh interval in nanoseconds
   localparam int REFRESH_CYCLE_GAP_PS = 75000;
   localparam int ACT_TO_ACT_GAP_PS = 15000;
   localparam int MODEREGSET_GAP_PS = 15000;
   localparam int POWERDOWN_EXIT_GAP_PS = 10000;
   localparam int SELFREF_EXIT_WRITE_GAP_PS = 95000;
   localparam int SELFREF_EXIT_ACT_GAP_PS = 75000;
   localparam int ACT_TO_COLUMN_GAP_PS = 20000;
   localparam int REFRESH_INTERVAL_NS = 7800;
   localparam int SWITCH_LEAD_ON_WRITE_PS = 4000;
   // counts in cycles, least times rounded up
   function automatic int up_cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int REFRESH_CYCLE_GAP_CYC = up_cyc(REFRESH_CYCLE_GAP_PS);
   localparam int ACT_TO_ACT_GAP_CYC = up_cyc(ACT_TO_ACT_GAP_PS);
   localparam int MODEREGSET_GAP_CYC = up_cyc(MODEREGSET_GAP_PS);
   localparam int POWERDOWN_EXIT_GAP_CYC = up_cyc(POWERDOWN_EXIT_GAP_PS);
   localparam int SELFREF_EXIT_WRITE_GAP_CYC = up_cyc(SELFREF_EXIT_WRITE_GAP_PS);
   localparam int SELFREF_EXIT_ACT_GAP_CYC = up_cyc(SELFREF_EXIT_ACT_GAP_PS);
   localparam int SELFREF_EXIT_READ_GAP_CYC = 200;
   localparam int ACT_TO_COLUMN_GAP_CYC = up_cyc(ACT_TO_COLUMN_GAP_PS);
   localparam int WRITE_TO_READ_GAP_CYC = 1;
   localparam int COL_TO_COL_GAP_CYC = 1;
   // a longest time rounds down
   localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS * 1000 / CLK_PS;
   localparam int MAX_REFRESH_BURST = 8;
   localparam int BURST_LEN = 4;
   localparam int CAS_LATENCY_SETTING = 2;
   localparam int TW = 10;
   localparam logic [TW-1:0] T_ZERO = 10'h000;
   localparam logic [TW-1:0] T_ONE = 10'h001;
   localparam logic [3:0] DEBT_ZERO = 4'h0;
   localparam logic [3:0] DEBT_MAX = 4'(MAX_REFRESH_BURST);
   localparam logic [15:0] RI_ZERO = 16'h0000;
   localparam int NBANK = 4;
   // command encoding on the link
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_READ = 4'h2, CMD_WRITE = 4'h3,
      CMD_PRE = 4'h4, CMD_REF = 4'h5, CMD_MRS = 4'h6, CMD_PDE = 4'h7,
      CMD_PDX = 4'h8, CMD_SRE = 4'h9, CMD_SRX = 4'hA
   } dtg_cmd_e;
endpackage
`default_nettype wire

//--- include/dtg_if.sv
/*
 link between controller and memory end: command, bank, and the
 fet switch control line returned by the memory.
 assumes both ends on the same MCLK.
*/
`timescale 1ns/1ps
`default_nettype none
interface dtg_if;
   import dtg_pkg::*;
   logic [3:0] cmd;
   logic [1:0] bank;
   logic fet_switch_ctl;
   modport ctl (output cmd, output bank, input fet_switch_ctl);
   modport mem (input cmd, input bank, output fet_switch_ctl);
endinterface
`default_nettype wire

//--- rtl/dtg_ctl.sv
/*
 controller end: takes user requests, holds countdowns, some shared by several
 spacing limits, and issues a command only when every limit that applies is met.
 assumes the memory end keeps its own switch timing; user holds a
 request until REQ_TAKEN pulses.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: wait refresh cycle gap after refresh
// R2: space activates to different banks
// R3: one cycle after write data before read
// R4: column commands may run back to back; the taken cycle leaves one idle cycle or more between any two commands
// R5: wait mode register gap after set
// R6: wait powerdown exit gap before command
// R7: wait selfref exit gap before write
// R8: wait selfref exit gap before activate
// R9: 200 cycles after selfref before read
// R10: write after activate needs column gap
// R11: average refresh spacing, at most 8 owed
// R12: clock period within legal range
// R13: read switch lead one clock before strobe
// R14: read switch tail half clock after strobe
// R15: write switch on within 4 ns
// R16: write switch release after last strobe
// R17: cut write releases switch within 1.5 clocks
// R18: ns limits rounded up into countdowns
// R19: per bank state gates legal commands
module dtg_ctl
   import dtg_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic REQ_VALID,
   input wire logic [3:0] REQ_CMD,
   input wire logic [1:0] REQ_BANK,
   output logic REQ_TAKEN,
   output logic REQ_ILLEGAL,
   output logic REFRESH_DUE,
   dtg_if.ctl link
);
   typedef struct packed {
      logic [3:0] cmd;
      logic [1:0] bank;
      logic taken;
      logic illegal;
      logic due;
      logic [TW-1:0] t_any;   // blocks every command
      logic [TW-1:0] t_act;
      logic [TW-1:0] t_rd;
      logic [TW-1:0] t_wr;
      logic [TW-1:0] t_col;
      logic [NBANK-1:0] open;
      logic [NBANK-1:0][TW-1:0] t_rcd;
      logic [15:0] ri;
      logic [3:0] debt;
      logic pd;
      logic sr;
   } dtg_ctl_s;
   dtg_ctl_s q, next_q;

   function automatic logic [TW-1:0] dec(input logic [TW-1:0] t);
      return (t == T_ZERO) ? T_ZERO : t - T_ONE;
   endfunction
   function automatic logic [TW-1:0] mx(input logic [TW-1:0] t, input int n);
      return (t > TW'(n)) ? t : TW'(n);
   endfunction

   // countdowns run, then a request is checked and issued
   always_comb
   begin
      logic ok;
      logic legal;
      dtg_cmd_e c;
      ok = 1'b0;
      legal = 1'b1;
      c = dtg_cmd_e'(REQ_CMD);
      next_q = q;
      next_q.cmd = CMD_NOP;
      next_q.taken = 1'b0;
      next_q.illegal = 1'b0;
      next_q.t_any = dec(q.t_any);
      next_q.t_act = dec(q.t_act);
      next_q.t_rd = dec(q.t_rd);
      next_q.t_wr = dec(q.t_wr);
      next_q.t_col = dec(q.t_col);
      for (int b = 0; b < NBANK; b++)
      begin
         next_q.t_rcd[b] = dec(q.t_rcd[b]);
      end
      // refresh owed accrues every interval, capped at the burst limit
      if (q.ri == RI_ZERO)
      begin
         next_q.ri = 16'(REFRESH_INTERVAL_CYC - 1);
         if (q.debt != DEBT_MAX)
         begin
            next_q.debt = q.debt + 4'h1; // [R11]
         end
      end
      else
      begin
         next_q.ri = q.ri - 16'h0001;
      end
      if (REQ_VALID && !q.taken)
      begin
         ok = (q.t_any == T_ZERO); // [R1] [R5] [R6]
         unique case (c)
            CMD_ACT:
            begin
               legal = !q.open[REQ_BANK] && !q.pd && !q.sr; // [R19]
               ok = ok && (q.t_act == T_ZERO); // [R2] [R8]
            end
            CMD_READ:
            begin
               legal = q.open[REQ_BANK] && !q.pd && !q.sr; // [R19]
               ok = ok && (q.t_rd == T_ZERO) && (q.t_col == T_ZERO) // [R3] [R4] [R9]
                  && (q.t_rcd[REQ_BANK] == T_ZERO);
            end
            CMD_WRITE:
            begin
               legal = q.open[REQ_BANK] && !q.pd && !q.sr; // [R19]
               ok = ok && (q.t_wr == T_ZERO) && (q.t_col == T_ZERO) // [R4] [R7]
                  && (q.t_rcd[REQ_BANK] == T_ZERO); // [R10]
            end
            CMD_REF, CMD_SRE, CMD_MRS:
            begin
               legal = (q.open == '0) && !q.pd && !q.sr; // [R19]
            end
            CMD_PRE, CMD_NOP:
            begin
               legal = !q.pd && !q.sr;
            end
            CMD_PDE:
            begin
               legal = !q.pd && !q.sr;
            end
            CMD_PDX:
            begin
               legal = q.pd;
            end
            CMD_SRX:
            begin
               legal = q.sr;
            end
            default:
            begin
               legal = 1'b0;
            end
         endcase
         if (!legal)
         begin
            next_q.taken = 1'b1;
            next_q.illegal = 1'b1;
         end
         else if (ok)
         begin
            next_q.taken = 1'b1;
            next_q.cmd = REQ_CMD;
            next_q.bank = REQ_BANK;
            unique case (c)
               CMD_ACT:
               begin
                  next_q.open[REQ_BANK] = 1'b1;
                  next_q.t_act = mx(next_q.t_act, ACT_TO_ACT_GAP_CYC); // [R2] [R18]
                  next_q.t_rcd[REQ_BANK] = TW'(ACT_TO_COLUMN_GAP_CYC); // [R10]
               end
               CMD_READ:
               begin
                  next_q.t_col = TW'(COL_TO_COL_GAP_CYC - 1); // [R4]
               end
               CMD_WRITE:
               begin
                  next_q.t_col = TW'(COL_TO_COL_GAP_CYC - 1); // [R4]
                  // last data lands burst/2 cycles on, then one idle clock
                  next_q.t_rd = mx(next_q.t_rd, BURST_LEN / 2 + WRITE_TO_READ_GAP_CYC); // [R3]
               end
               CMD_PRE:
               begin
                  next_q.open[REQ_BANK] = 1'b0;
               end
               CMD_REF:
               begin
                  next_q.t_any = TW'(REFRESH_CYCLE_GAP_CYC - 1); // [R1] [R18]
                  if (next_q.debt != DEBT_ZERO)
                  begin
                     next_q.debt = next_q.debt - 4'h1; // [R11]
                  end
               end
               CMD_MRS:
               begin
                  next_q.t_any = TW'(MODEREGSET_GAP_CYC - 1); // [R5]
               end
               CMD_PDE:
               begin
                  next_q.pd = 1'b1;
               end
               CMD_PDX:
               begin
                  next_q.pd = 1'b0;
                  next_q.t_any = TW'(POWERDOWN_EXIT_GAP_CYC - 1); // [R6]
               end
               CMD_SRE:
               begin
                  next_q.sr = 1'b1;
               end
               CMD_SRX:
               begin
                  next_q.sr = 1'b0;
                  next_q.debt = DEBT_ZERO;
                  next_q.t_act = mx(next_q.t_act, SELFREF_EXIT_ACT_GAP_CYC); // [R8]
                  next_q.t_wr = mx(next_q.t_wr, SELFREF_EXIT_WRITE_GAP_CYC); // [R7]
                  next_q.t_rd = mx(next_q.t_rd, SELFREF_EXIT_READ_GAP_CYC); // [R9]
               end
               default:
               begin
               end
            endcase
         end
      end
      next_q.due = (next_q.debt != DEBT_ZERO); // [R11]
   end

   // one register for all state; clock fixed at 8 ns, inside 7.5..15 ns [R12]
   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         q <= '0;
         q.ri <= 16'(REFRESH_INTERVAL_CYC - 1);
      end
      else
      begin
         q <= next_q;
      end
   end

   assign link.cmd = q.cmd;
   assign link.bank = q.bank;
   assign REQ_TAKEN = q.taken;
   assign REQ_ILLEGAL = q.illegal;
   assign REFRESH_DUE = q.due;
endmodule // dtg_ctl
`default_nettype wire

//--- rtl/dtg_mem.sv
/*
 memory end: watches commands and drives the fet switch control output
 around read and write bursts, cycle quantised at MCLK.
 assumes the controller keeps every command spacing limit.
*/
`timescale 1ns/1ps
`default_nettype none
module dtg_mem
   import dtg_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   output logic RD_BURST,
   output logic WR_BURST,
   dtg_if.mem link
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b001, S_RD = 3'b010, S_WR = 3'b100
   } dtg_mem_e;
   typedef struct packed {
      dtg_mem_e st;
      logic [3:0] cnt;
      logic sw;
      logic rd;
      logic wr;
   } dtg_mem_s;
   dtg_mem_s q, next_q;

   // read: switch rises CL-1 cycles on, one clock ahead of first strobe,
   // holds through burst; write: switch rises on the command edge
   always_comb
   begin
      next_q = q;
      unique case (q.st)
         S_IDLE:
         begin
            next_q.sw = 1'b0;
            if (link.cmd == CMD_READ)
            begin
               next_q.st = S_RD;
               next_q.cnt = 4'(CAS_LATENCY_SETTING + BURST_LEN / 2); // [R13] [R14]
            end
            else if (link.cmd == CMD_WRITE)
            begin
               next_q.st = S_WR;
               next_q.sw = 1'b1; // [R15]
               next_q.cnt = 4'(BURST_LEN / 2 + 1); // [R16]
            end
         end
         S_RD:
         begin
            next_q.sw = 1'b1; // [R13]
            if (link.cmd == CMD_READ)
            begin
               next_q.cnt = 4'(CAS_LATENCY_SETTING + BURST_LEN / 2);
            end
            else if (link.cmd == CMD_WRITE)
            begin
               // bus turns round to a write; switch stays on throughout
               next_q.st = S_WR;
               next_q.cnt = 4'(BURST_LEN / 2 + 1); // [R15]
            end
            else if (q.cnt == 4'h0)
            begin
               next_q.st = S_IDLE; // [R14]
               next_q.sw = 1'b0;
            end
            else
            begin
               next_q.cnt = q.cnt - 4'h1;
            end
         end
         S_WR:
         begin
            next_q.sw = 1'b1;
            if (link.cmd == CMD_WRITE)
            begin
               next_q.cnt = 4'(BURST_LEN / 2 + 1);
            end
            else if (link.cmd == CMD_READ)
            begin
               // a read right behind a write must not be lost
               next_q.st = S_RD;
               next_q.cnt = 4'(CAS_LATENCY_SETTING + BURST_LEN / 2); // [R13] [R14]
            end
            else if (link.cmd == CMD_PRE || q.cnt == 4'h0)
            begin
               next_q.st = S_IDLE; // [R16] [R17]
               next_q.sw = 1'b0;
            end
            else
            begin
               next_q.cnt = q.cnt - 4'h1;
            end
         end
         default:
         begin
            next_q.st = S_IDLE;
            next_q.sw = 1'b0;
         end
      endcase
      // burst flags kept as flops so the outputs need no decode
      next_q.rd = (next_q.st == S_RD);
      next_q.wr = (next_q.st == S_WR);
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         q <= '{st: S_IDLE, cnt: 4'h0, sw: 1'b0, rd: 1'b0, wr: 1'b0};
      end
      else
      begin
         q <= next_q;
      end
   end

   assign link.fet_switch_ctl = q.sw;
   assign RD_BURST = q.rd;
   assign WR_BURST = q.wr;
endmodule // dtg_mem
`default_nettype wire

//--- test/dtg_chk_sva.sv
/* checker: link spacing and fet switch timing.
 assumes one clock, sync high reset, placed beside the link. */
`timescale 1ns/1ps
`default_nettype none
module dtg_chk
   import dtg_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [3:0] cmd,
   input wire logic [1:0] bank,
   input wire logic fet_switch_ctl
);
   logic [7:0] srx_age;
   logic wr_last;
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   // cycles since self-refresh exit; saturates so a cold start counts as long ago
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         srx_age <= 8'hFF;
      else if (cmd == CMD_SRX)
         srx_age <= 8'h01;
      else if (srx_age != 8'hFF)
         srx_age <= srx_age + 8'h01;
   end
   // last column command was a write
   always_ff @(posedge MCLK)
   begin
      if (SRST)
         wr_last <= 1'b0;
      else if (cmd == CMD_WRITE)
         wr_last <= 1'b1;
      else if (cmd == CMD_READ)
         wr_last <= 1'b0;
   end
   chk_ref_gap: assert property (cmd == CMD_REF |=> (cmd == CMD_NOP)[*8] ##1 cmd == CMD_NOP)
      else $error("command too soon after refresh");
   chk_mrs_gap: assert property (cmd == CMD_MRS |=> cmd == CMD_NOP)
      else $error("command too soon after mode set");
   chk_pdx_gap: assert property (cmd == CMD_PDX |=> cmd == CMD_NOP)
      else $error("command too soon after powerdown exit");
   chk_srx_write: assert property (cmd == CMD_WRITE |-> srx_age >= 8'h0C)
      else $error("write too soon after selfref exit");
   chk_srx_act: assert property (cmd == CMD_ACT |-> srx_age >= 8'h0A)
      else $error("activate too soon after selfref exit");
   chk_srx_read: assert property (cmd == CMD_READ |-> srx_age >= 8'hC8)
      else $error("read too soon after selfref exit");
   chk_wr_rd: assert property (cmd == CMD_WRITE |=> (cmd != CMD_READ)[*2])
      else $error("read too soon after write");
   chk_rd_switch: assert property (cmd == CMD_READ |-> ##3 fet_switch_ctl[*3])
      else $error("switch not held over read burst");
   chk_wr_switch: assert property (cmd == CMD_WRITE |=> fet_switch_ctl)
      else $error("switch late on write");
   chk_cut_write: assert property (cmd == CMD_PRE && wr_last && fet_switch_ctl |=> !fet_switch_ctl)
      else $error("switch held after cut write");
   chk_act_gap: assert property (cmd == CMD_ACT |=>
      !(cmd == CMD_ACT && bank != $past(bank)))
      else $error("activates to two banks too close");
endmodule // dtg_chk
`default_nettype wire

//--- test/test_ddr_command_timing_guard.sv
/* bench: both ends joined by the link, user requests driven.
 assumes package, link and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_ddr_command_timing_guard;
   import dtg_pkg::*;
   typedef struct {logic ill; logic [3:0] cmd; int back; int gap;} dtg_exp_s;
   logic MCLK = 1'b0;
   logic SRST = 1'b1;
   logic REQ_VALID = 1'b0;
   logic [3:0] REQ_CMD = 4'h0;
   logic [1:0] REQ_BANK = 2'h0;
   logic REQ_TAKEN, REQ_ILLEGAL, REFRESH_DUE, RD_BURST, WR_BURST;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   int seed = 32'hD1E8;
   logic [3:0] seen = 4'h0;
   int hist[$];
   dtg_exp_s expq[$];
   logic [1:0] b;
   dtg_if dtg_if_inst ();
   dtg_ctl dtg_ctl_inst (.MCLK(MCLK), .SRST(SRST), .REQ_VALID(REQ_VALID),
      .REQ_CMD(REQ_CMD), .REQ_BANK(REQ_BANK), .REQ_TAKEN(REQ_TAKEN),
      .REQ_ILLEGAL(REQ_ILLEGAL), .REFRESH_DUE(REFRESH_DUE), .link(dtg_if_inst));
   dtg_mem dtg_mem_inst (.MCLK(MCLK), .SRST(SRST), .RD_BURST(RD_BURST),
      .WR_BURST(WR_BURST), .link(dtg_if_inst));
   dtg_chk dtg_chk_inst (.MCLK(MCLK), .SRST(SRST), .cmd(dtg_if_inst.cmd),
      .bank(dtg_if_inst.bank), .fet_switch_ctl(dtg_if_inst.fet_switch_ctl));
   always #4 MCLK = ~MCLK;
   task automatic cmp_val(input string nm, input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_gap(input string nm, input int e, input int g);
      tests_run++;
      if (g < e)
      begin
         fails++;
         $display("MISMATCH %s expected >=%0d seen %0d", nm, e, g);
      end
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // called at a falling edge; returns at the falling edge that sees it taken,
   // request still up, so a next call follows at once (taken cycle blocks it)
   task automatic req(input logic [3:0] c, input logic [1:0] bk, input logic ill,
      input int back, input int gap);
      int k;
      REQ_VALID = 1'b1;
      REQ_CMD = c;
      REQ_BANK = bk;
      expq.push_back('{ill, c, back, gap});
      k = 0;
      do
      begin
         @(negedge MCLK);
         k++;
      end
      while (REQ_TAKEN !== 1'b1 && k < 400);
      if (REQ_TAKEN !== 1'b1)
         fails++;
   endtask
   // drop the request at a falling edge, then let one clock pass
   task automatic rel();
      REQ_VALID = 1'b0;
      REQ_CMD = 4'($random(seed)); // noise, valid is low
      @(negedge MCLK);
   endtask
   // take the oldest note on each answer; log issue cycles for spacing
   always @(posedge MCLK)
   begin
      dtg_exp_s x;
      cyc++;
      if (!SRST && REQ_TAKEN === 1'b1 && expq.size() > 0)
      begin
         x = expq.pop_front();
         cmp_val("illegal", {3'h0, x.ill}, {3'h0, REQ_ILLEGAL});
         cmp_val("link cmd", x.ill ? 4'h0 : x.cmd, dtg_if_inst.cmd);
         if (x.gap > 0)
            cmp_gap("spacing", x.gap, cyc - hist[hist.size() - x.back]);
      end
      if (!SRST && dtg_if_inst.cmd !== 4'h0)
         hist.push_back(cyc);
      // burst state follows one clock after the command appears on the link
      if (!SRST && seen == CMD_WRITE)
         cmp_val("write burst", 4'h1, {3'h0, WR_BURST});
      if (!SRST && seen == CMD_READ)
         cmp_val("read burst", 4'h1, {3'h0, RD_BURST});
      seen = dtg_if_inst.cmd;
   end
   initial
   begin
      b = 2'($random(seed));
      repeat (2) @(posedge MCLK);
      @(negedge MCLK);
      SRST = 1'b0;
      req(CMD_ACT, b, 1'b0, 0, 0);
      req(CMD_ACT, b, 1'b1, 0, 0);
      req(CMD_ACT, b + 2'h1, 1'b0, 1, 2);
      req(CMD_WRITE, b + 2'h1, 1'b0, 1, 3);
      req(CMD_READ, b + 2'h1, 1'b0, 1, 2);
      req(CMD_READ, b + 2'h1, 1'b0, 1, 1);
      req(CMD_NOP, b + 2'h1, 1'b0, 0, 0); // idle slot; the read burst is still running when the write reaches the memory end
      req(CMD_WRITE, b + 2'h1, 1'b0, 1, 1);
      req(CMD_PRE, b + 2'h1, 1'b0, 0, 0);
      req(CMD_PRE, b, 1'b0, 0, 0);
      note("columns");
      req(CMD_REF, b, 1'b0, 0, 0);
      req(CMD_MRS, b, 1'b0, 1, 10);
      req(CMD_PDE, b, 1'b0, 1, 2);
      req(CMD_PDX, b, 1'b0, 0, 0);
      req(CMD_ACT, b, 1'b0, 1, 2);
      req(CMD_PRE, b, 1'b0, 0, 0);
      note("modes");
      req(CMD_SRE, b, 1'b0, 0, 0);
      req(CMD_SRX, b, 1'b0, 0, 0);
      req(CMD_ACT, b, 1'b0, 1, 10);
      req(CMD_WRITE, b, 1'b0, 2, 12);
      req(CMD_READ, b, 1'b0, 3, 200);
      req(CMD_PRE, b, 1'b0, 0, 0);
      note("selfref");
      rel();
      cmp_val("refresh due", 4'h0, {3'h0, REFRESH_DUE});
      n = 0;
      while (REFRESH_DUE !== 1'b1 && n < 1000)
      begin
         n++;
         @(negedge MCLK);
      end
      cmp_val("refresh due", 4'h1, {3'h0, REFRESH_DUE});
      req(CMD_REF, b, 1'b0, 0, 0);
      rel();
      cmp_val("refresh due", 4'h0, {3'h0, REFRESH_DUE});
      note("refresh");
      summarize();
   end
   // hang guard, well beyond the roughly 1000 cycles the tests need
   initial
   begin
      repeat (5000) @(posedge MCLK);
      fails++;
      summarize();
   end
endmodule // test_ddr_command_timing_guard
`default_nettype wire
